/* hw/fcra_top.sv */
// Top of the flash code-read accelerator: prefetch, wait states, loop cache.
// What this block does
// - First sequential access waits states plus one.
// - Loop optimisation only while enable bit set.
// - Loop enable bit comes up set after reset.
// - Disabled or sequential-off bypasses loop buffers.
// - Backward jump switches to loop read path.
// - First backward branch caches two target cells.
// - Prefetch plus loop cache gives wait-free loops.
`timescale 1ns/1ps
`default_nettype none
module fcra_top #(
	parameter int unsigned CELL_W = fcra_pkg::CELL_BITS,
	parameter int unsigned ADDR_W = fcra_pkg::ADDR_BITS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [fcra_pkg::WS_BITS-1:0] flash_wait_states,
	input wire logic cfg_write,
	input wire logic loop_opt_enable_in,
	input wire logic sequential_opt_disable_in,
	input wire logic fetch_req,
	input wire logic [ADDR_W-1:0] fetch_addr,
	output logic fetch_ready,
	output logic [CELL_W-1:0] fetch_data,
	output logic fetch_from_loop,
	output logic loop_opt_enable,
	output logic sequential_opt_disable,
	output logic flash_req,
	output logic [ADDR_W-1:0] flash_addr,
	input wire logic [CELL_W-1:0] flash_rdata
);
	localparam int unsigned TAG_W = ADDR_W - fcra_pkg::CELL_LSB;
	// ==========================================
	// Flash mode register bits
	// Both bits load from one write, so the loop path is never left half enabled.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			loop_opt_enable <= fcra_pkg::LOOP_OPT_RESET;
			sequential_opt_disable <= fcra_pkg::SEQ_DIS_RESET;
		end else if (cfg_write) begin
			loop_opt_enable <= loop_opt_enable_in;
			sequential_opt_disable <= sequential_opt_disable_in;
		end
	end

	logic loop_on;
	assign loop_on = loop_opt_enable && !sequential_opt_disable;

	// ==========================================
	// Fetch engine
	fcra_pkg::fcra_state_type state_q;
	logic [fcra_pkg::WS_BITS-1:0] cnt_q;
	logic [TAG_W-1:0] last_tag_q;
	logic last_vld_q;
	logic [TAG_W-1:0] req_tag;
	logic seq_hit;
	logic backward;
	logic loop_hit;
	logic [CELL_W-1:0] loop_data;
	logic [TAG_W-1:0] cur_tag_q;
	logic [CELL_W-1:0] pf_data_q;
	logic pf_vld_q;
	logic [TAG_W-1:0] pf_tag_q;
	logic fill_now;
	logic take;
	logic fast_hit;
	logic answer_now;
	logic capture_now;
	logic pf_load_q;
	logic cache_fill;
	logic [TAG_W-1:0] cache_fill_tag;
	localparam logic [fcra_pkg::CELL_LSB-1:0] CELL_ZERO = '0;

	// ==========================================
	// Cell decoding
	function automatic logic [TAG_W-1:0] cell_of(input logic [ADDR_W-1:0] addr);
		cell_of = addr[ADDR_W-1:fcra_pkg::CELL_LSB];
	endfunction

	function automatic logic [TAG_W-1:0] next_cell(input logic [TAG_W-1:0] tag);
		next_cell = tag + TAG_W'(1'h1);
	endfunction

	assign req_tag = cell_of(fetch_addr);
	assign backward = last_vld_q && req_tag < last_tag_q;
	// Sequential hits come from the prefetched next cell, ready one cycle after.
	assign seq_hit = !sequential_opt_disable && pf_vld_q && pf_tag_q == req_tag;
	assign fill_now = state_q == fcra_pkg::FCRA_WAIT && cnt_q == '0;
	// A request still held while its answer stands must not be taken a second time.
	assign take = state_q == fcra_pkg::FCRA_IDLE && fetch_req && !fetch_ready;
	assign fast_hit = (loop_hit && loop_on) || seq_hit;
	assign answer_now = fill_now || (take && fast_hit);
	assign capture_now = take && backward && !loop_hit && loop_on;
	// The loop cache fills from demand misses and from the prefetch of the following cell.
	assign cache_fill = (fill_now || pf_load_q) && loop_on;
	assign cache_fill_tag = pf_load_q ? cell_of(flash_addr) : cur_tag_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= fcra_pkg::FCRA_IDLE;
			cnt_q <= '0;
			cur_tag_q <= '0;
		end else begin
			unique case (state_q)
				fcra_pkg::FCRA_IDLE: begin
					if (take && !fast_hit) begin
						state_q <= fcra_pkg::FCRA_WAIT;
						cnt_q <= flash_wait_states;
						cur_tag_q <= req_tag;
					end
				end
				fcra_pkg::FCRA_WAIT: begin
					if (cnt_q == '0) begin
						state_q <= fcra_pkg::FCRA_DONE;
					end else begin
						cnt_q <= cnt_q - 1'h1;
					end
				end
				fcra_pkg::FCRA_DONE: begin
					// This cycle carries the prefetch read that follows a miss.
					state_q <= fcra_pkg::FCRA_IDLE;
				end
				// The unused code 2'h2 is never entered; it falls back to idle should it appear.
				default: begin
					state_q <= fcra_pkg::FCRA_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Answer and history
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fetch_ready <= 1'h0;
			fetch_data <= '0;
			fetch_from_loop <= 1'h0;
			last_vld_q <= 1'h0;
			last_tag_q <= '0;
		end else begin
			fetch_ready <= 1'h0;
			fetch_from_loop <= 1'h0;
			// Loop hits win over the prefetch, so the loop flag marks every cached cell served.
			if (take && loop_hit && loop_on) begin
				fetch_ready <= 1'h1;
				fetch_data <= loop_data;
				fetch_from_loop <= 1'h1;
				last_tag_q <= req_tag;
				last_vld_q <= 1'h1;
			end else if (take && seq_hit) begin
				fetch_ready <= 1'h1;
				fetch_data <= pf_data_q;
				last_tag_q <= req_tag;
				last_vld_q <= 1'h1;
			end else if (fill_now) begin
				fetch_ready <= 1'h1;
				fetch_data <= flash_rdata;
				last_tag_q <= cur_tag_q;
				last_vld_q <= 1'h1;
			end
		end
	end

	// ==========================================
	// Flash port and next-cell prefetch
	// The cycle after each answer reads the following cell, so a straight run of fetches waits only on its first cell while sequential_opt_disable is clear.
	// The port is taken to return a cell in that one cycle; a slower array needs a wider read here.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			flash_req <= 1'h0;
			pf_load_q <= 1'h0;
		end else begin
			flash_req <= take && !fast_hit;
			pf_load_q <= answer_now;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			flash_addr <= '0;
		end else if (answer_now) begin
			flash_addr <= {next_cell(fill_now ? cur_tag_q : req_tag), CELL_ZERO};
		end else if (take) begin
			flash_addr <= {req_tag, CELL_ZERO};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pf_vld_q <= 1'h0;
			pf_tag_q <= '0;
			pf_data_q <= '0;
		end else if (pf_load_q) begin
			pf_vld_q <= 1'h1;
			pf_tag_q <= cell_of(flash_addr);
			pf_data_q <= flash_rdata;
		end else if (take) begin
			pf_vld_q <= 1'h0;
		end
	end

	// ==========================================
	// Loop-entry cache
	// Disabling the loop path clears the cache, so re-enabling it never serves old cells.
	fcra_loop_cache #(
		.CELL_W(CELL_W),
		.TAG_W(TAG_W)
	) u_loop (
		.clk(clk),
		.rst_b(rst_b),
		.enable(loop_on),
		.capture_start(capture_now),
		.start_tag(req_tag),
		.fill_valid(cache_fill),
		.fill_tag(cache_fill_tag),
		.fill_data(flash_rdata),
		.look_tag(req_tag),
		.hit(loop_hit),
		.hit_data(loop_data)
	);
endmodule
`default_nettype wire

/* hw/fcra_pkg.sv */
// Package of constants and types for the flash code-read accelerator.
package fcra_pkg;
	// ==========================================
	// Geometry
	localparam int unsigned CELL_BITS = 128;
	localparam int unsigned ADDR_BITS = 28;
	localparam int unsigned CELL_LSB = 4;
	localparam int unsigned WS_BITS = 4;
	localparam int unsigned LOOP_CELLS = 2;
	// ==========================================
	// Reset values
	localparam logic LOOP_OPT_RESET = 1'h1;
	localparam logic SEQ_DIS_RESET = 1'h0;
	localparam logic [3:0] WS_RESET = 4'h0;
	// ==========================================
	// Fetch engine states
	typedef enum logic [1:0] {
		FCRA_IDLE = 2'h0,
		FCRA_WAIT = 2'h1,
		FCRA_DONE = 2'h3
	} fcra_state_type;
endpackage

/* hw/fcra_loop_cache.sv */
// Two-cell loop-entry cache holding the cells at a backward-branch target.
`timescale 1ns/1ps
`default_nettype none
module fcra_loop_cache #(
	parameter int unsigned CELL_W = fcra_pkg::CELL_BITS,
	parameter int unsigned TAG_W = fcra_pkg::ADDR_BITS - fcra_pkg::CELL_LSB
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic capture_start,
	input wire logic [TAG_W-1:0] start_tag,
	input wire logic fill_valid,
	input wire logic [TAG_W-1:0] fill_tag,
	input wire logic [CELL_W-1:0] fill_data,
	input wire logic [TAG_W-1:0] look_tag,
	output logic hit,
	output logic [CELL_W-1:0] hit_data
);
	// ==========================================
	// Storage
	logic [TAG_W-1:0] base_q;
	logic [fcra_pkg::LOOP_CELLS-1:0] valid_q;
	logic [CELL_W-1:0] data_q [fcra_pkg::LOOP_CELLS];
	logic [TAG_W-1:0] off;

	always_ff @(posedge clk) begin
		if (!rst_b || !enable) begin
			valid_q <= '0;
		end else if (capture_start) begin
			valid_q <= '0;
		end else if (fill_valid && fill_tag - base_q < TAG_W'(fcra_pkg::LOOP_CELLS)) begin
			valid_q[fill_tag[0] ^ base_q[0]] <= 1'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			base_q <= '0;
		end else if (capture_start) begin
			base_q <= start_tag;
		end
	end

	always_ff @(posedge clk) begin
		// Only cells inside the window are kept, so a far fill cannot overwrite a valid entry.
		if (fill_valid && !capture_start && fill_tag - base_q < TAG_W'(fcra_pkg::LOOP_CELLS)) begin
			data_q[fill_tag[0] ^ base_q[0]] <= fill_data;
		end
	end

	always_comb begin
		off = look_tag - base_q;
		hit = 1'h0;
		hit_data = data_q[look_tag[0] ^ base_q[0]];
		if (enable && off < TAG_W'(fcra_pkg::LOOP_CELLS)) begin
			hit = valid_q[look_tag[0] ^ base_q[0]];
		end
	end
endmodule
`default_nettype wire

/* dv/fcra_flash_model.sv */
// Flash array stand-in for the accelerator's far side.
`timescale 1ns/1ps
`default_nettype none
module fcra_flash_model (
	input wire logic [fcra_pkg::ADDR_BITS-1:0] flash_addr,
	output logic [fcra_pkg::CELL_BITS-1:0] flash_rdata
);
	// ==========================================
	// Array
	// Every word carries the cell index, so a wrong or stale cell shows.
	assign flash_rdata = {4{4'h5, flash_addr[27:4], 4'h0}};
endmodule
`default_nettype wire

/* dv/fcra_properties.sv */
// Checker of fetch timing and loop-cache use at the top ports.
`timescale 1ns/1ps
`default_nettype none
module fcra_properties (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [fcra_pkg::WS_BITS-1:0] flash_wait_states,
	input wire logic cfg_write,
	input wire logic loop_opt_enable_in,
	input wire logic sequential_opt_disable_in,
	input wire logic fetch_ready,
	input wire logic fetch_from_loop,
	input wire logic loop_opt_enable,
	input wire logic sequential_opt_disable,
	input wire logic flash_req,
	input wire logic [fcra_pkg::ADDR_BITS-1:0] flash_addr
);
	// ==========================================
	// Miss age
	// Counts cycles since the flash request rose; the wait-state figure is a level, so no delay can hold it.
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [4:0] age_q;
	logic [4:0] ws;
	assign ws = 5'(flash_wait_states);
	always_ff @(posedge clk) begin
		if (!rst_b || fetch_ready) age_q <= 5'h0;
		else if ($rose(flash_req)) age_q <= 5'h1;
		else if (age_q != 5'h0 && age_q != 5'h1F) age_q <= age_q + 5'h1;
	end
	// ==========================================
	// Properties
	property p_reset_mode; $rose(rst_b) |-> loop_opt_enable && !sequential_opt_disable; endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("mode bits wrong after reset");
	property p_cfg; cfg_write |=> loop_opt_enable == $past(loop_opt_enable_in)
		&& sequential_opt_disable == $past(sequential_opt_disable_in); endproperty
	a_cfg: assert property (p_cfg) else $error("mode bits not loaded");
	property p_loop_enabled; fetch_from_loop |-> loop_opt_enable && !sequential_opt_disable; endproperty
	a_loop_enabled: assert property (p_loop_enabled) else $error("loop hit while disabled");
	property p_with_ready; fetch_from_loop |-> fetch_ready; endproperty
	a_with_ready: assert property (p_with_ready) else $error("loop flag without answer");
	property p_miss_wait; age_q != 5'h0 && age_q <= ws |-> !fetch_ready; endproperty
	a_miss_wait: assert property (p_miss_wait) else $error("miss answered early");
	property p_miss_done; age_q == ws + 5'h1 |-> fetch_ready && !fetch_from_loop; endproperty
	a_miss_done: assert property (p_miss_done) else $error("miss answered late");
	property p_cell; flash_req |-> flash_addr[3:0] == 4'h0; endproperty
	a_cell: assert property (p_cell) else $error("flash address not cell aligned");
	property p_hit_fast; fetch_from_loop |-> !flash_req && age_q == 5'h0; endproperty
	a_hit_fast: assert property (p_hit_fast) else $error("loop hit waited on flash");
endmodule
bind fcra_top fcra_properties chk (.clk(clk), .rst_b(rst_b), .flash_wait_states(flash_wait_states),
	.cfg_write(cfg_write), .loop_opt_enable_in(loop_opt_enable_in), .fetch_ready(fetch_ready),
	.sequential_opt_disable_in(sequential_opt_disable_in), .fetch_from_loop(fetch_from_loop),
	.loop_opt_enable(loop_opt_enable), .sequential_opt_disable(sequential_opt_disable),
	.flash_req(flash_req), .flash_addr(flash_addr));
`default_nettype wire

/* dv/flash_code_read_accelerator_test.sv */
// Self-checking bench for the flash code-read accelerator.
`timescale 1ns/1ps
`default_nettype none
module flash_code_read_accelerator_test;
	// ==========================================
	// Signals
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] ws = 4'h1;
	logic cfg_write = 1'b0, cfg_loop = 1'b1, cfg_off = 1'b0, fetch_req = 1'b0;
	logic [27:0] fetch_addr = 28'h0, flash_addr;
	logic fetch_ready, fetch_from_loop, lo, so, flash_req;
	logic [127:0] fetch_data, flash_rdata;
	logic [128:0] exp_q[$];
	int errors = 0, samples_checked = 0, seed = 32'h2DA2;
	always #2 clk = ~clk;
	fcra_top uut (.clk(clk), .rst_b(rst_b), .flash_wait_states(ws), .cfg_write(cfg_write),
		.loop_opt_enable_in(cfg_loop), .sequential_opt_disable_in(cfg_off), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_data(fetch_data),
		.fetch_from_loop(fetch_from_loop), .loop_opt_enable(lo), .sequential_opt_disable(so),
		.flash_req(flash_req), .flash_addr(flash_addr), .flash_rdata(flash_rdata));
	fcra_flash_model flash (.flash_addr(flash_addr), .flash_rdata(flash_rdata));
	// ==========================================
	// Tasks
	task automatic chk(input string what, input logic [128:0] seen, input logic [128:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic fetch(input logic [27:0] a, input logic hit, input logic fast);
		int n;
		exp_q.push_back({hit, {4{4'h5, a[27:4], 4'h0}}});
		@(posedge clk);
		fetch_req <= 1'b1;
		fetch_addr <= a;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (fetch_ready !== 1'b1 && n < 20);
		fetch_req <= 1'b0;
		chk("latency", 129'(n), fast ? 129'h2 : 129'(ws) + 129'h3);
		if (n >= 20) begin
			errors++;
			finish_test();
		end
	endtask
	// A loop is captured on its first backward jump; its second cell hits on that pass, both from the next.
	task automatic run_loop(input logic [27:0] base, input logic opt, input logic seq);
		for (int it = 0; it < 4; it++) begin
			for (int c = 0; c < 4; c++) begin
				fetch(base + 28'(c * 16), opt && (it >= 2 ? c < 2 : it == 1 && c == 1),
					(seq && c != 0) || (opt && it >= 2));
			end
		end
	endtask
	task automatic set_mode(input logic en, input logic off);
		@(posedge clk);
		cfg_write <= 1'b1;
		cfg_loop <= en;
		cfg_off <= off;
		ws <= 4'h1 + 4'($unsigned($random(seed)) % 3);
		@(posedge clk);
		cfg_write <= 1'b0;
		@(posedge clk);
		chk("mode", {127'h0, lo, so}, {127'h0, en, off});
	endtask
	// ==========================================
	// Checking and sequence
	always @(posedge clk) begin
		if (rst_b && fetch_ready === 1'b1) begin
			chk("fetch", {fetch_from_loop, fetch_data}, exp_q.size() > 0 ? exp_q.pop_front() : 129'h0);
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk("reset mode", {127'h0, lo, so}, {127'h0, 2'h2});
		set_mode(1'b1, 1'b0);
		run_loop(28'h0001000, 1'b1, 1'b1);
		set_mode(1'b0, 1'b0);
		run_loop(28'h0002000, 1'b0, 1'b1);
		set_mode(1'b1, 1'b1);
		run_loop(28'h0003000, 1'b0, 1'b0);
		set_mode(1'b1, 1'b0);
		run_loop(28'h0004000, 1'b1, 1'b1);
		run_loop(28'h0005000, 1'b1, 1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
